// [logic/fvom_mapper.sv]
// output process-data mapper driving solenoid valve points
//
// What this block does
// - accepts scanner output data and drives 16 or 32 valve outputs from it.
// - returns a two-byte input image, all bits reserved and zero.
// - word 0 bits drive points 0..15; word 1 drives points 16..31.
// - output assembly is 100 for 16 points, 101 for 32 points.
// - output assembly is 2 bytes for 16 points, 4 bytes for 32 points.
// - error state and polarity come from unit settings, not process data.
`timescale 1ns/1ps
`include "fvom_regs.svh"
module fvom_mapper
   import fvom_pkg::*;
#(
   parameter bit WIDE = 1'b1
) (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   // cyclic output data from the scanner
   input  wire logic        out_valid_in,
   input  wire logic [7:0]  out_instance_in,
   input  wire logic [2:0]  out_size_in,
   input  wire logic [31:0] out_data_in,
   // connection state
   input  wire logic        comm_error_in,
   // unit settings
   input  wire logic        hold_on_error_in,
   input  wire logic        sourcing_output_polarity_in,
   // input image back to the scanner
   output logic [15:0]      in_data_out,
   output logic [2:0]       in_size_out,
   output logic [7:0]       in_instance_out,
   // acceptance
   output logic             out_ready_out,
   output logic             out_accept_out,
   output logic             out_reject_out,
   // solenoid drive
   output logic [31:0]      valve_on_out,
   output logic             sinking_output_polarity_out,
   output logic             sourcing_output_polarity_out,
   output logic             outputs_live_out
);
   localparam int POINTS = WIDE ? `FVOM_POINTS_32 : `FVOM_POINTS_16;

   fvom_state_t state_r;
   fvom_state_t state_nxt;
   logic        accept;
   logic        load;
   logic [31:0] load_data;
   logic [31:0] image;
   logic        accept_r;
   logic        reject_r;
   logic        pol_r;

   function automatic logic conn_ok(input logic [7:0] inst,
                                    input logic [2:0] size);
      if (WIDE) begin
         conn_ok = (inst == `FVOM_ASM_OUT_32)
                && (size == `FVOM_OUT_BYTES_32);
      end else begin
         conn_ok = (inst == `FVOM_ASM_OUT_16)
                && (size == `FVOM_OUT_BYTES_16);
      end
   endfunction

   // only matching instance and size are taken
   assign accept = out_valid_in && !comm_error_in
                && conn_ok(out_instance_in, out_size_in);
   assign out_ready_out = 1'b1;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         FVOM_IDLE: begin
            if (accept) begin
               state_nxt = FVOM_RUN;
            end
         end
         FVOM_RUN: begin
            if (comm_error_in) begin
               state_nxt = FVOM_FAULT;
            end
         end
         FVOM_FAULT: begin
            if (accept) begin
               state_nxt = FVOM_RUN;
            end
         end
         default: begin
            state_nxt = FVOM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         state_r <= FVOM_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // upper word masked off on the narrow unit
   always_comb begin
      load      = 1'b0;
      load_data = '0;
      if (accept) begin
         load      = 1'b1;
         load_data = WIDE ? out_data_in
                          : {16'h0000, out_data_in[15:0]};
      end else if (state_r == FVOM_RUN && comm_error_in
                   && !hold_on_error_in) begin
         load      = 1'b1; // error state from unit setting
         load_data = '0;
      end
   end

   fvom_out_latch #(
      .WIDTH (32)
   ) u_latch (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .load_in   (load),
      .data_in   (load_data),
      .q_out     (image)
   );

   assign valve_on_out     = image;
   assign outputs_live_out = (state_r != FVOM_IDLE);

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         accept_r <= 1'b0;
         reject_r <= 1'b0;
      end else begin
         accept_r <= accept;
         reject_r <= out_valid_in && !accept;
      end
   end
   assign out_accept_out = accept_r;
   assign out_reject_out = reject_r;

   // polarity is a strap-like setting; sampled every clock, not from data
   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         pol_r <= 1'b0;
      end else begin
         pol_r <= sourcing_output_polarity_in;
      end
   end
   assign sourcing_output_polarity_out = pol_r;
   assign sinking_output_polarity_out  = !pol_r;

   // input image: fixed reserved bytes regardless of variant
   assign in_data_out     = `FVOM_IN_IMAGE;
   assign in_size_out     = `FVOM_IN_BYTES;
   assign in_instance_out = `FVOM_ASM_IN;

   // mapping; a taken frame shows one edge after it is sampled
   outputs_dark_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (state_r == FVOM_IDLE) |-> (valve_on_out == 32'h0))
      else $error("outputs energised before first data");
   map_load_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      accept |=> (valve_on_out[15:0] == $past(out_data_in[15:0])))
      else $error("low word not mapped");
   upper_word_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (accept && WIDE)
      |=> (valve_on_out[31:16] == $past(out_data_in[31:16])))
      else $error("high word not mapped");
   narrow_high_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      !WIDE |-> (valve_on_out[31:16] == 16'h0))
      else $error("narrow unit drives upper points");
   points_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (valve_on_out >> POINTS) == 32'h0)
      else $error("point beyond the variant energised");
   hold_image_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (!accept && !(state_r == FVOM_RUN && comm_error_in
                    && !hold_on_error_in))
      |=> $stable(valve_on_out))
      else $error("outputs changed without a frame");
   accept_pulse_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      accept |=> (out_accept_out && !out_reject_out && outputs_live_out))
      else $error("taken frame not acknowledged");
   // refusals leave the solenoid image alone, except in the cycle the error clear fires
   wrong_conn_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (out_valid_in && !conn_ok(out_instance_in, out_size_in)
       && !(state_r == FVOM_RUN && comm_error_in && !hold_on_error_in))
      |=> out_reject_out && $stable(valve_on_out))
      else $error("mismatched connection changed outputs");
   size_check_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      accept |-> (out_size_in == (WIDE ? `FVOM_OUT_BYTES_32
                                       : `FVOM_OUT_BYTES_16)))
      else $error("wrong size accepted");
   error_refuse_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (out_valid_in && comm_error_in) |=> (out_reject_out && !out_accept_out))
      else $error("frame taken during communication error");
   input_image_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (in_data_out == 16'h0) && (in_size_out == 3'h2))
      else $error("input image not reserved two bytes");
   // unit settings; a fresh frame may follow the clear at once
   error_clear_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (state_r == FVOM_RUN && comm_error_in && !hold_on_error_in)
      |=> (valve_on_out == 32'h0)
          ##1 (out_accept_out || (valve_on_out == 32'h0)))
      else $error("error clear state not applied");
   error_hold_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      (state_r == FVOM_RUN && comm_error_in && hold_on_error_in)
      |=> $stable(valve_on_out))
      else $error("error hold state not applied");
   polarity_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      sourcing_output_polarity_out != sinking_output_polarity_out)
      else $error("polarity outputs disagree");
   polarity_follow_a: assert property (@(posedge clock_in)
      disable iff (!resetn_in)
      $past(resetn_in) |-> (sourcing_output_polarity_out
                            == $past(sourcing_output_polarity_in)))
      else $error("polarity setting not followed");
endmodule

// [logic/fvom_out_latch.sv]
// output latch holding the solenoid image
`timescale 1ns/1ps
module fvom_out_latch #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input  wire logic             clock_in,
   input  wire logic             resetn_in,
   // load port
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] data_in,
   // image
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] q_r;

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         q_r <= '0;
      end else if (load_in) begin
         q_r <= data_in;
      end
   end

   assign q_out = q_r;
endmodule

// [logic/fvom_pkg.sv]
// types for the valve output mapper
package fvom_pkg;
   typedef enum logic [1:0] {
      FVOM_IDLE,
      FVOM_RUN,
      FVOM_FAULT
   } fvom_state_t;
endpackage

// [logic/fvom_regs.svh]
// constants for the valve output mapper
`ifndef FVOM_REGS_SVH
`define FVOM_REGS_SVH
`define FVOM_POINTS_16       16
`define FVOM_POINTS_32       32
`define FVOM_OUT_BYTES_16    3'h2
`define FVOM_OUT_BYTES_32    3'h4
`define FVOM_IN_BYTES        3'h2
`define FVOM_IN_CONN_BYTES   3'h6
`define FVOM_IN_HDR_BYTES    3'h4
`define FVOM_ASM_OUT_16      8'h64
`define FVOM_ASM_OUT_32      8'h65
`define FVOM_ASM_IN          8'h6e
`define FVOM_IN_IMAGE        16'h0000
`endif

// [verification/fvom_scanner_model.sv]
// scanner model sending cyclic output frames to the valve mapper
`timescale 1ns/1ps
module fvom_scanner_model (
   // clock and device image size
   input  wire logic        clock_in,
   input  wire logic [2:0]  in_size_in,
   // output frame towards the device
   output logic             out_valid_out,
   output logic [7:0]       out_instance_out,
   output logic [2:0]       out_size_out,
   output logic [31:0]      out_data_out,
   // input connection size the scanner configures
   output logic [2:0]       conn_bytes_out
);
   // four header bytes ahead of the device image
   assign conn_bytes_out = 3'h4 + in_size_in;
   initial begin
      out_valid_out = 1'b0;
      out_instance_out = 8'h00;
      out_size_out = 3'h0;
      out_data_out = 32'h0000_0000;
   end
   // one frame per call; lines turn over once released, never keep old data
   task automatic send(input logic [7:0] inst, input logic [2:0] size,
                       input logic [31:0] data);
      @(posedge clock_in);
      #1;
      out_valid_out = 1'b1;
      out_instance_out = inst;
      out_size_out = size;
      out_data_out = data;
      @(posedge clock_in);
      #1;
      out_valid_out = 1'b0;
      out_instance_out = ~inst;
      out_size_out = ~size;
      out_data_out = ~data;
   endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the valve output mapper
`timescale 1ns/1ps
module testbench;
   logic clock_in, resetn_in, comm_error_in, hold_in, src_in;
   logic valid, ready, accept, reject, sink_o, src_o, live;
   logic [7:0] inst, in_inst;
   logic [2:0] size, in_size, conn;
   logic [31:0] data, valve;
   logic [15:0] in_data;
   int err_total, checked;
   logic n_valid, n_accept, n_reject, n_live;
   logic [7:0] n_inst;
   logic [2:0] n_size, n_in_size, n_conn;
   logic [31:0] n_data, n_valve;
   logic [15:0] n_in_data;
   fvom_mapper #(.WIDE(1'b1)) i_dut (.clock_in(clock_in),
      .resetn_in(resetn_in), .out_valid_in(valid), .out_instance_in(inst),
      .out_size_in(size), .out_data_in(data), .comm_error_in(comm_error_in),
      .hold_on_error_in(hold_in), .sourcing_output_polarity_in(src_in),
      .in_data_out(in_data), .in_size_out(in_size),
      .in_instance_out(in_inst), .out_ready_out(ready),
      .out_accept_out(accept), .out_reject_out(reject),
      .valve_on_out(valve), .sinking_output_polarity_out(sink_o),
      .sourcing_output_polarity_out(src_o), .outputs_live_out(live));
   fvom_scanner_model i_scan (.clock_in(clock_in), .in_size_in(in_size),
      .out_valid_out(valid), .out_instance_out(inst), .out_size_out(size),
      .out_data_out(data), .conn_bytes_out(conn));
   fvom_mapper #(.WIDE(1'b0)) i_dut_n (.clock_in(clock_in),
      .resetn_in(resetn_in), .out_valid_in(n_valid),
      .out_instance_in(n_inst), .out_size_in(n_size),
      .out_data_in(n_data), .comm_error_in(comm_error_in),
      .hold_on_error_in(hold_in), .sourcing_output_polarity_in(src_in),
      .in_data_out(n_in_data), .in_size_out(n_in_size),
      .in_instance_out(), .out_ready_out(), .out_accept_out(n_accept),
      .out_reject_out(n_reject), .valve_on_out(n_valve),
      .sinking_output_polarity_out(), .sourcing_output_polarity_out(),
      .outputs_live_out(n_live));
   fvom_scanner_model i_scan_n (.clock_in(clock_in),
      .in_size_in(n_in_size), .out_valid_out(n_valid),
      .out_instance_out(n_inst), .out_size_out(n_size),
      .out_data_out(n_data), .conn_bytes_out(n_conn));
   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   task automatic chk(input string name, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic end_of_test();
      if (err_total == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_edges(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic t_reset();
      chk("valve", 32'h0, valve);
      chk("valve_n", 32'h0, n_valve);
      chk("live", 32'h0, {31'h0, live});
      chk("in_data", 32'h0, {16'h0, in_data});
      chk("in_size", 32'h2, {29'h0, in_size});
      chk("in_inst", 32'h6e, {24'h0, in_inst});
      chk("conn", 32'h6, {29'h0, conn});
      chk("sinking", 32'h1, {31'h0, sink_o});
      chk("ready", 32'h1, {31'h0, ready});
   endtask
   task automatic t_accept(input logic [31:0] d);
      i_scan.send(8'h65, 3'h4, d);
      chk("valve", d, valve);
      chk("accept", 32'h1, {31'h0, accept});
      chk("live", 32'h1, {31'h0, live});
      chk("in_data", 32'h0, {16'h0, in_data});
   endtask
   task automatic t_refuse(input logic [7:0] i, input logic [2:0] s);
      i_scan.send(i, s, 32'hffff_0000);
      chk("reject", 32'h1, {31'h0, reject});
      chk("accept", 32'h0, {31'h0, accept});
      chk("valve", 32'h8001_0002, valve);
   endtask
   task automatic t_error();
      hold_in = 1'b1;
      comm_error_in = 1'b1;
      wait_edges(2);
      chk("valve_hold", 32'h8001_0002, valve);
      i_scan.send(8'h65, 3'h4, 32'h1234_5678);
      chk("reject_err", 32'h1, {31'h0, reject});
      comm_error_in = 1'b0;
      t_accept(32'h0f0f_f0f0);
      hold_in = 1'b0;
      comm_error_in = 1'b1;
      wait_edges(2);
      chk("valve_clear", 32'h0, valve);
      comm_error_in = 1'b0;
      src_in = 1'b1;
      wait_edges(2);
      chk("sourcing", 32'h1, {31'h0, src_o});
      chk("sinking", 32'h0, {31'h0, sink_o});
   endtask
   // narrow unit: refused frames first, so outputs must still be dark
   task automatic t_narrow();
      i_scan_n.send(8'h65, 3'h4, 32'hffff_ffff);
      chk("reject_n", 32'h1, {31'h0, n_reject});
      chk("valve_n", 32'h0, n_valve);
      chk("live_n", 32'h0, {31'h0, n_live});
      i_scan_n.send(8'h64, 3'h4, 32'hffff_ffff);
      chk("reject_n", 32'h1, {31'h0, n_reject});
      i_scan_n.send(8'h64, 3'h2, 32'hffff_a5c3);
      chk("accept_n", 32'h1, {31'h0, n_accept});
      chk("valve_n", 32'h0000_a5c3, n_valve);
      chk("live_n", 32'h1, {31'h0, n_live});
      chk("in_data_n", 32'h0, {16'h0, n_in_data});
      chk("in_size_n", 32'h2, {29'h0, n_in_size});
      chk("conn_n", 32'h6, {29'h0, n_conn});
   endtask
   initial begin
      #20000;
      err_total++;
      end_of_test();
   end
   initial begin
      err_total = 0;
      checked = 0;
      resetn_in = 1'b0;
      comm_error_in = 1'b0;
      hold_in = 1'b0;
      src_in = 1'b0;
      wait_edges(4);
      t_reset();
      resetn_in = 1'b1;
      wait_edges(1);
      t_reset();
      t_accept(32'hc3a5_5a3c);
      t_accept(32'h8001_0002);
      t_refuse(8'h64, 3'h4);
      t_refuse(8'h65, 3'h2);
      t_narrow();
      t_error();
      end_of_test();
   end
endmodule
